// ===== cell_balance_status_regs.sv
// Balance status register bank: elapsed timer, undervoltage flags, state mirrors, transfer strobe
//
// Function
// - Report 10-bit elapsed time in selected unit
// - Hold period: timer reads the expiry setting
// - Infinite expiry: timer keeps counting and wraps
// - Infinite expiry: activity counter keeps counting
// - Two-bit state: disabled, active, done, halted
// - State mirrored in uv and transfer registers
// - Set per-cell uv flag below threshold, stop
// - Uv flags clear on disable or new start
// - Unsupported measurement stops cell, sets flag
// - Ready set by transfer, write zero clears
// - Strobe copies iir results, self-clears, gated
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "cbsr_regs.svh"
module cell_balance_status_regs
  import cbsr_pkg::*;
#(
  parameter int unsigned CELLS       = 14,
  parameter int unsigned TICK_CYCLES = `CBSR_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       sys_rst_in,
  // Register port
  input  wire logic [`CBSR_ADDR_W-1:0]    reg_addr_in,
  input  wire logic [`CBSR_DATA_W-1:0]    reg_wdata_in,
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  output logic [`CBSR_DATA_W-1:0]         reg_rdata_out,
  // Balancing engine status
  input  wire logic [9:0]                 balance_expiry_setting_in,
  input  wire logic                       balance_expired_in,
  input  wire logic                       thermal_exit_alert_in,
  input  wire logic                       timeout_exit_alert_in,
  input  wire logic                       calibration_exit_alert_in,
  input  wire logic                       hold_period_in,
  // Per-cell measurement status
  input  wire logic [CELLS-1:0]           cell_below_uv_in,
  input  wire logic [CELLS-1:0]           cell_meas_unsupported_in,
  input  wire logic                       uv_check_valid_in,
  // Measurement data path
  input  wire logic                       scan_data_ready_in,
  input  wire logic                       iir_copy_done_in,
  output logic                            iir_transfer_out,
  // Balance switch drive
  output logic [CELLS-1:0]                cell_balance_on_out,
  output logic                            balance_running_out
);
  typedef struct packed {
    logic [15:0]    ctrl;
    logic [15:0]    cfg;
    cbsr_state_type state;
    logic [9:0]     timer;
    logic [1:0]     cntr;
    logic [CELLS-1:0] uv_flags;
    logic           ready;
    logic           xfer;
    logic [15:0]    rdata;
    logic           run;
    logic [CELLS-1:0] bal_on;
  } cbsr_st_type;
  cbsr_st_type s_q, s_d;

  cbsr_tick_if tk ();
  logic          unit_tick;
  logic [2:0]    mode;
  logic [1:0]    hold_sel;
  logic [1:0]    meas_en;
  cbsr_unit_type unit;
  logic          start_wr;
  logic          disable_wr;
  logic          cfg_wr;
  logic          data_wr;
  logic          uv_check_on;
  logic [CELLS-1:0] uv_hits;
  logic [9:0]    timer_view;
  logic [15:0]   rd_mux;

  ////////////////////////////////////////////////////////////////
  // Timebase
  cbsr_second_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .tk         (tk.source)
  );

  cbsr_unit_prescaler u_pre (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .clear_in      (start_wr | disable_wr),
    .second_in     (tk.tick),
    .unit_in       (unit),
    .unit_tick_out (unit_tick)
  );

  ////////////////////////////////////////////////////////////////
  // Decode of controls and register writes
  assign mode        = s_q.ctrl[`CBSR_MODE_MSB:0];
  assign hold_sel    = s_q.cfg[`CBSR_HOLD_MSB:`CBSR_HOLD_LSB];
  assign meas_en     = s_q.cfg[`CBSR_MEAS_MSB:`CBSR_MEAS_LSB];
  assign cfg_wr      = reg_wr_in && reg_addr_in == `CBSR_OFF_BAL_CFG;
  assign data_wr     = reg_wr_in && reg_addr_in == `CBSR_OFF_DATA_XFER;
  // Any control write starts a new operation or disables
  assign start_wr    = reg_wr_in && reg_addr_in == `CBSR_OFF_BAL_CTRL
                       && reg_wdata_in[`CBSR_MODE_MSB:0] != 3'h0;
  assign disable_wr  = reg_wr_in && reg_addr_in == `CBSR_OFF_BAL_CTRL
                       && reg_wdata_in[`CBSR_MODE_MSB:0] == 3'h0;
  assign uv_check_on = meas_en == 2'b11 && uv_check_valid_in;
  assign tk.clear    = start_wr | disable_wr;

  // Unit follows mode: off, seconds, minutes or hours
  always_comb begin
    case (mode)
      3'h0:                unit = CBSR_UNIT_OFF;
      3'h3, 3'h6:          unit = CBSR_UNIT_SEC;
      3'h4, 3'h7:          unit = CBSR_UNIT_MIN;
      default:             unit = CBSR_UNIT_HR;
    endcase
  end

  // Per-cell exit detection
  genvar g;
  generate
    for (g = 0; g < CELLS; g++) begin : g_cell
      assign uv_hits[g] = (uv_check_on && cell_below_uv_in[g])
                          || (meas_en[1] && cell_meas_unsupported_in[g]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.xfer = 1'b0;
    if (cfg_wr) begin
      s_d.cfg = reg_wdata_in;
    end
    if (reg_wr_in && reg_addr_in == `CBSR_OFF_BAL_CTRL) begin
      s_d.ctrl = reg_wdata_in;
    end
    // Status runs while an operation is active; the activity counter also runs in a hold period unless disabled
    if (s_q.state == CBSR_ST_ACTIVE) begin
      if (tk.tick) begin
        s_d.cntr = s_q.cntr + 2'h1;
      end
      if (unit_tick) begin
        s_d.timer = s_q.timer + 10'h1;
      end
      s_d.uv_flags = s_q.uv_flags | uv_hits;
      if (thermal_exit_alert_in || timeout_exit_alert_in || calibration_exit_alert_in) begin
        s_d.state = CBSR_ST_HALTED;
      end else if ((balance_expired_in && balance_expiry_setting_in != `CBSR_EXP_INFINITE)
                   || (&(s_q.uv_flags | uv_hits))) begin
        s_d.state = CBSR_ST_DONE;
      end
    end else if (hold_sel[1] && hold_period_in && s_q.state != CBSR_ST_DISABLED) begin
      if (tk.tick) begin
        s_d.cntr = s_q.cntr + 2'h1;
      end
    end
    // Strobe: gated by mode and measurement enable
    if (data_wr && reg_wdata_in[`CBSR_STROBE_BIT] && meas_en[1]
        && mode != 3'h0 && mode != 3'h1) begin
      s_d.xfer = 1'b1;
    end
    // Ready: write zero clears, a new transfer wins
    if (data_wr && !reg_wdata_in[`CBSR_READY_BIT]) begin
      s_d.ready = 1'b0;
    end
    if (iir_copy_done_in || scan_data_ready_in) begin
      s_d.ready = 1'b1;
    end
    // Start or disable sets state, clears timer, activity counter and uv flags
    if (start_wr) begin
      s_d.state    = CBSR_ST_ACTIVE;
      s_d.timer    = '0;
      s_d.cntr     = '0;
      s_d.uv_flags = '0;
    end else if (disable_wr) begin
      s_d.state    = CBSR_ST_DISABLED;
      s_d.timer    = '0;
      s_d.cntr     = '0;
      s_d.uv_flags = '0;
    end
    s_d.rdata = reg_rd_in ? rd_mux : 16'h0000;
    // Switch drive and running flag follow the next state so the outputs leave flops
    s_d.run    = s_d.state == CBSR_ST_ACTIVE;
    s_d.bal_on = (s_d.state == CBSR_ST_ACTIVE) ? ~s_d.uv_flags : '0;
  end

  ////////////////////////////////////////////////////////////////
  // Read path, function of state, address, hold period and expiry setting
  assign timer_view = (hold_sel[1] && hold_period_in) ? balance_expiry_setting_in : s_q.timer;

  always_comb begin
    rd_mux = 16'h0000;
    case (reg_addr_in)
      `CBSR_OFF_STATUS: begin
        rd_mux[`CBSR_STATE_MSB:`CBSR_STATE_LSB] = s_q.state;
        rd_mux[`CBSR_UNIT_MSB:`CBSR_UNIT_LSB]   = unit;
        rd_mux[`CBSR_CNTR_MSB:`CBSR_CNTR_LSB]   = s_q.cntr;
        rd_mux[`CBSR_TIMER_MSB:0]               = timer_view;
      end
      `CBSR_OFF_UV_SUMMARY: begin
        rd_mux[`CBSR_STATE_MSB:`CBSR_STATE_LSB] = s_q.state;
        rd_mux[CELLS-1:0]                       = s_q.uv_flags;
      end
      `CBSR_OFF_DATA_XFER: begin
        rd_mux[`CBSR_STATE_MSB:`CBSR_STATE_LSB] = s_q.state;
        rd_mux[`CBSR_READY_BIT]                 = s_q.ready;  // strobe bit reads zero
      end
      `CBSR_OFF_BAL_CTRL: rd_mux = s_q.ctrl;
      `CBSR_OFF_BAL_CFG:  rd_mux = s_q.cfg;
      default:            rd_mux = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s_q       <= '0;
      s_q.ctrl  <= `CBSR_CTRL_RESET;
      s_q.cfg   <= `CBSR_CFG_RESET;
      s_q.state <= CBSR_ST_DISABLED;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata_out       = s_q.rdata;
  assign iir_transfer_out    = s_q.xfer;
  assign balance_running_out = s_q.run;
  assign cell_balance_on_out = s_q.bal_on;
endmodule

// ===== cbsr_regs.svh
// Register offsets, field positions, reset values and timing counts for the balance status block
`ifndef CBSR_REGS_SVH
`define CBSR_REGS_SVH
`define CBSR_ADDR_W            8
`define CBSR_DATA_W            16
`define CBSR_OFF_STATUS        8'h81
`define CBSR_OFF_UV_SUMMARY    8'h82
`define CBSR_OFF_DATA_XFER     8'h83
`define CBSR_OFF_BAL_CTRL      8'h90
`define CBSR_OFF_BAL_CFG       8'h91
`define CBSR_STATE_MSB         15
`define CBSR_STATE_LSB         14
`define CBSR_UNIT_MSB          13
`define CBSR_UNIT_LSB          12
`define CBSR_CNTR_MSB          11
`define CBSR_CNTR_LSB          10
`define CBSR_TIMER_MSB         9
`define CBSR_READY_BIT         13
`define CBSR_STROBE_BIT        0
`define CBSR_MODE_MSB          2
`define CBSR_HOLD_MSB          9
`define CBSR_HOLD_LSB          8
`define CBSR_MEAS_MSB          1
`define CBSR_MEAS_LSB          0
`define CBSR_CTRL_RESET        16'h0000
`define CBSR_CFG_RESET         16'h0000
`define CBSR_EXP_INFINITE      10'h3ff
`define CBSR_CLK_HZ            200000000
`define CBSR_TICK_PERIOD_S     1
`define CBSR_TICK_CYCLES       (`CBSR_CLK_HZ * `CBSR_TICK_PERIOD_S)
`endif

// ===== cbsr_pkg.sv
// Types shared by the balance status block
package cbsr_pkg;
  typedef enum logic [1:0] {
    CBSR_ST_DISABLED = 2'b00,
    CBSR_ST_ACTIVE   = 2'b01,
    CBSR_ST_DONE     = 2'b10,
    CBSR_ST_HALTED   = 2'b11
  } cbsr_state_type;
  typedef enum logic [1:0] {
    CBSR_UNIT_OFF = 2'b00,
    CBSR_UNIT_SEC = 2'b01,
    CBSR_UNIT_MIN = 2'b10,
    CBSR_UNIT_HR  = 2'b11
  } cbsr_unit_type;
endpackage

// ===== cbsr_tick_if.sv
// Interface carrying the one-second tick and its reset between modules
`timescale 1ns/1ps
interface cbsr_tick_if;
  logic tick;
  logic clear;
  modport source (output tick, input clear);
  modport sink   (input tick, output clear);
endinterface

// ===== cbsr_second_tick.sv
// One-second tick generator
`timescale 1ns/1ps
`include "cbsr_regs.svh"
module cbsr_second_tick
  import cbsr_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `CBSR_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  // Tick link
  cbsr_tick_if.source     tk
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } cbsr_tick_st_type;
  cbsr_tick_st_type s_q, s_d;

  ////////////////////////////////////////////////////////////////
  // Count clock cycles, pulse once per period
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (tk.clear) begin
      s_d.cnt = '0;
    end else if (s_q.cnt == TICK_CYCLES - 1) begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tk.tick = s_q.tick;
endmodule

// ===== cbsr_unit_prescaler.sv
// Divides the second tick into the elapsed timer's unit tick
`timescale 1ns/1ps
`include "cbsr_regs.svh"
module cbsr_unit_prescaler
  import cbsr_pkg::*;
(
  // Clock and reset
  input  wire logic          clk_in,
  input  wire logic          sys_rst_in,
  // Control
  input  wire logic          clear_in,
  input  wire logic          second_in,
  input  wire cbsr_unit_type unit_in,
  // Result
  output logic               unit_tick_out
);
  typedef struct packed {
    logic [11:0] cnt;
    logic        tick;
  } cbsr_pre_st_type;
  cbsr_pre_st_type s_q, s_d;
  logic [11:0] limit;

  ////////////////////////////////////////////////////////////////
  // Seconds per unit minus one
  always_comb begin
    case (unit_in)
      CBSR_UNIT_MIN: limit = 12'h03b;
      CBSR_UNIT_HR:  limit = 12'he0f;
      default:       limit = 12'h000;
    endcase
  end

  // Count seconds and emit one tick per unit
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (clear_in || unit_in == CBSR_UNIT_OFF) begin
      s_d.cnt = '0;
    end else if (second_in) begin
      if (s_q.cnt >= limit) begin
        s_d.cnt  = '0;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 12'h1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign unit_tick_out = s_q.tick;
endmodule

// ===== cell_balance_status_regs_properties.sv
// Port-level properties of the balance status register bank
`timescale 1ns/1ps
module cbsr_checker
  import cbsr_pkg::*;
#(
  parameter int unsigned CELLS = 14
) (
  // Clock and reset
  input wire logic             clk_in,
  input wire logic             sys_rst_in,
  // Register port
  input wire logic [7:0]       reg_addr_in,
  input wire logic [15:0]      reg_wdata_in,
  input wire logic             reg_wr_in,
  input wire logic             reg_rd_in,
  input wire logic [15:0]      reg_rdata_out,
  // Engine status
  input wire logic [9:0]       balance_expiry_setting_in,
  input wire logic             balance_expired_in,
  input wire logic             thermal_exit_alert_in,
  input wire logic             timeout_exit_alert_in,
  input wire logic             calibration_exit_alert_in,
  input wire logic             hold_period_in,
  // Outputs
  input wire logic             iir_transfer_out,
  input wire logic [CELLS-1:0] cell_balance_on_out,
  input wire logic             balance_running_out
);
  // Decoded requests and halt causes
  wire alert      = thermal_exit_alert_in | timeout_exit_alert_in | calibration_exit_alert_in;
  wire ctrl_wr    = reg_wr_in && reg_addr_in == 8'h90;
  wire strobe_req = reg_wr_in && reg_addr_in == 8'h83 && reg_wdata_in[0];
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  ////////////////////////////////////////
  property p_start;
    ctrl_wr && reg_wdata_in[2:0] != 3'h0 && !alert && !balance_expired_in |=> balance_running_out;
  endproperty
  a_start: assert property (p_start) else $error("start did not activate");
  property p_stop;
    ctrl_wr && reg_wdata_in[2:0] == 3'h0 |=> !balance_running_out && cell_balance_on_out == '0;
  endproperty
  a_stop: assert property (p_stop) else $error("disable left balancing on");
  property p_halt;
    alert && balance_running_out && !ctrl_wr |=> !balance_running_out;
  endproperty
  a_halt: assert property (p_halt) else $error("alert did not halt");
  property p_strobe;
    iir_transfer_out |-> $past(strobe_req);
  endproperty
  a_strobe: assert property (p_strobe) else $error("transfer without strobe");
  property p_rd_idle;
    !$past(reg_rd_in) |-> reg_rdata_out == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_xfer_low;
    reg_rd_in && reg_addr_in == 8'h83 |=> reg_rdata_out[12:0] == 13'h0000;
  endproperty
  a_xfer_low: assert property (p_xfer_low) else $error("unused transfer bits set");
  property p_mirror;
    reg_rd_in && reg_addr_in inside {8'h81, 8'h82, 8'h83}
      |=> (reg_rdata_out[15:14] == 2'h1) == $past(balance_running_out);
  endproperty
  a_mirror: assert property (p_mirror) else $error("state mirror mismatch");
  property p_uv_drive;
    reg_rd_in && reg_addr_in == 8'h82 && balance_running_out
      |=> reg_rdata_out[13:0] == ~$past(cell_balance_on_out);
  endproperty
  a_uv_drive: assert property (p_uv_drive) else $error("flagged cell still on");
  property p_hold;
    reg_rd_in && reg_addr_in == 8'h81 && hold_period_in && balance_running_out
      |=> reg_rdata_out[9:0] == $past(balance_expiry_setting_in);
  endproperty
  a_hold: assert property (p_hold) else $error("hold timer not expiry");
endmodule

bind cell_balance_status_regs cbsr_checker #(.CELLS(CELLS)) chk (.clk_in, .sys_rst_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .balance_expiry_setting_in, .balance_expired_in,
  .thermal_exit_alert_in, .timeout_exit_alert_in, .calibration_exit_alert_in, .hold_period_in,
  .iir_transfer_out, .cell_balance_on_out, .balance_running_out);

// ===== cell_balance_status_regs_test.sv
// Self-checking bench for the balance status register bank
`timescale 1ns/1ps
module cell_balance_status_regs_test;
  import cbsr_pkg::*;
  localparam int unsigned TICK = 20;
  // Design ports
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [7:0]  reg_addr_in = 8'h00;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [15:0] reg_rdata_out;
  logic [9:0]  balance_expiry_setting_in = 10'h000;
  logic        balance_expired_in = 1'b0;
  logic [2:0]  alert = 3'h0;
  logic        hold_period_in = 1'b0;
  logic [13:0] cell_below_uv_in = 14'h0000;
  logic [13:0] cell_meas_unsupported_in = 14'h0000;
  logic        uv_check_valid_in = 1'b0;
  logic        scan_data_ready_in = 1'b0;
  logic        iir_copy_done_in = 1'b0;
  logic        iir_transfer_out;
  logic [13:0] cell_balance_on_out;
  logic        balance_running_out;
  // Expectation queues and bench state
  logic [15:0] mq[$];
  logic [15:0] vq[$];
  logic        iq[$];
  logic        rd_seen = 1'b0;
  logic        wr_seen = 1'b0;
  logic [15:0] seed = 16'h0063;
  logic [15:0] e;
  int          k;
  int          checks = 0;
  int          miscompares = 0;

  // Clock at 200 MHz
  always #2.5 clk_in = ~clk_in;

  cell_balance_status_regs #(.CELLS(14), .TICK_CYCLES(TICK)) uut (.clk_in, .sys_rst_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .balance_expiry_setting_in, .balance_expired_in,
    .thermal_exit_alert_in(alert[2]), .timeout_exit_alert_in(alert[1]), .calibration_exit_alert_in(alert[0]),
    .hold_period_in, .cell_below_uv_in, .cell_meas_unsupported_in, .uv_check_valid_in, .scan_data_ready_in,
    .iir_copy_done_in, .iir_transfer_out, .cell_balance_on_out, .balance_running_out);
  ////////////////////////////////////////
  // Helpers: comparison, bus cycles, stimulus source
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic p);
    iq.push_back(p);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    cyc(1);
    reg_wr_in <= 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] v);
    mq.push_back(m);
    vq.push_back(v);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    cyc(1);
    reg_rd_in <= 1'b0;
    cyc(1);
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [1:0] unit_of(input int m);
    case (m)
      0: return 2'h0;
      3, 6: return 2'h1;
      4, 7: return 2'h2;
      default: return 2'h3;
    endcase
  endfunction
  task automatic test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Compares each result with the oldest note when it appears
  always @(posedge clk_in) begin
    if (rd_seen) begin
      check("reg_rdata_out", reg_rdata_out & mq.pop_front(), vq.pop_front());
    end
    if (wr_seen) begin
      check("iir_transfer_out", {15'h0000, iir_transfer_out}, {15'h0000, iq.pop_front()});
    end
    rd_seen <= reg_rd_in;
    wr_seen <= reg_wr_in;
  end

  // Watchdog against a hang
  initial begin
    cyc(30000);
    miscompares++;
    test_done;
  end
  ////////////////////////////////////////
  // Main sequence
  initial begin
    cyc(5);
    sys_rst_in <= 1'b0;
    cyc(1);
    rd(8'h82, 16'hffff, 16'h0000);
    rd(8'h83, 16'hffff, 16'h0000);
    rd(8'h40, 16'hffff, 16'h0000);
    wr(8'h91, 16'h0003, 1'b0);
    for (int m = 0; m < 8; m++) begin
      wr(8'h90, 16'(m), 1'b0);
      rd(8'h81, 16'hf000, {(m == 0) ? 2'h0 : 2'h1, unit_of(m), 12'h000});
      wr(8'h83, 16'h0001, m > 1);
    end
    wr(8'h91, 16'h0001, 1'b0);
    wr(8'h83, 16'h0001, 1'b0);
    wr(8'h91, 16'h0003, 1'b0);
    // Elapsed seconds, then wrap with infinite expiry
    wr(8'h90, 16'h0003, 1'b0);
    cyc(TICK * 11 / 2);
    rd(8'h81, 16'hf3fc, 16'h5004);
    balance_expiry_setting_in <= 10'h3ff;
    balance_expired_in <= 1'b1;
    wr(8'h90, 16'h0003, 1'b0);
    cyc(TICK * 1026);
    rd(8'h81, 16'hc3fc, 16'h4000);
    balance_expiry_setting_in <= 10'h005;
    cyc(2);
    rd(8'h82, 16'hc000, 16'h8000);
    balance_expired_in <= 1'b0;
    // Hold period shows the expiry setting
    seed = lfsr(seed);
    balance_expiry_setting_in <= {1'b0, seed[8:0]};
    wr(8'h91, 16'h0203, 1'b0);
    hold_period_in <= 1'b1;
    wr(8'h90, 16'h0003, 1'b0);
    rd(8'h81, 16'h03ff, {7'h00, seed[8:0]});
    hold_period_in <= 1'b0;
    wr(8'h91, 16'h0003, 1'b0);
    // Undervoltage and unsupported-measurement flags
    seed = lfsr(seed);
    k = seed % 14;
    cell_below_uv_in <= 14'h0001 << k;
    uv_check_valid_in <= 1'b1;
    cyc(2);
    cell_below_uv_in <= 14'h0000;
    cell_meas_unsupported_in <= 14'h0001 << ((k + 5) % 14);
    cyc(2);
    cell_meas_unsupported_in <= 14'h0000;
    uv_check_valid_in <= 1'b0;
    e = 16'h4000 | (16'h0001 << k) | (16'h0001 << ((k + 5) % 14));
    rd(8'h82, 16'hffff, e);
    rd(8'h82, 16'hffff, e);
    check("cell_balance_on_out", {2'h0, cell_balance_on_out}, {2'h0, ~e[13:0]});
    wr(8'h90, 16'h0003, 1'b0);
    rd(8'h82, 16'hffff, 16'h4000);
    cell_meas_unsupported_in <= 14'h2000;
    cyc(2);
    cell_meas_unsupported_in <= 14'h0000;
    wr(8'h90, 16'h0000, 1'b0);
    rd(8'h82, 16'hffff, 16'h0000);
    // Each halt cause
    for (int a = 0; a < 3; a++) begin
      wr(8'h90, 16'h0003, 1'b0);
      alert <= 3'h4 >> a;
      cyc(2);
      alert <= 3'h0;
      rd(8'h83, 16'hc000, 16'hc000);
      check("balance_running_out", {15'h0000, balance_running_out}, 16'h0000);
    end
    // Transfer strobe and results-ready mirror
    wr(8'h90, 16'h0003, 1'b0);
    wr(8'h83, 16'h0001, 1'b1);
    iir_copy_done_in <= 1'b1;
    cyc(1);
    iir_copy_done_in <= 1'b0;
    rd(8'h83, 16'hffff, 16'h6000);
    wr(8'h83, 16'h2000, 1'b0);
    rd(8'h83, 16'hffff, 16'h6000);
    wr(8'h83, 16'h0000, 1'b0);
    rd(8'h83, 16'hffff, 16'h4000);
    scan_data_ready_in <= 1'b1;
    cyc(1);
    scan_data_ready_in <= 1'b0;
    rd(8'h83, 16'hffff, 16'h6000);
    cyc(2);
    test_done;
  end
endmodule
